// *** src/trigger_route_matrix.sv ***
// trigger route matrix: apb registers steering faceplate, bus lines and soft level
// assumes inputs synchronous to clock; pads resolve the open enables outside
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module trigger_route_matrix (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        coax_in,
  output logic             coax_out,
  output logic             coax_oe,
  input  wire logic [7:0]  line_in,
  output logic [7:0]       line_out,
  output logic [7:0]       line_oe
);
  logic       acc_stb;
  logic       path_ok;
  logic       open_q, open_d;
  logic       lvl_q, lvl_d;
  logic [7:0] src_q, src_d, dst_q, dst_d, hop_q, hop_d;
  logic       notopn_q, notopn_d, badset_q, badset_d;
  logic [31:0] prdata_q, prdata_d;
  logic       pslverr_q, pslverr_d;
  logic       coax_out_q, coax_out_d, coax_oe_q, coax_oe_d;
  logic [7:0] line_out_q, line_out_d, line_oe_q, line_oe_d;
  logic [7:0] w_src, w_dst, w_hop;
  logic       wr, rd;

  trm_apb_slave u_apb (
    .clock   (clock),
    .sys_rst (sys_rst),
    .psel    (psel),
    .penable (penable),
    .pready  (pready),
    .acc_stb (acc_stb)
  );

  assign w_src = pwdata[trm_pkg::PATH_SRC_LSB +: trm_pkg::SEL_W];
  assign w_dst = pwdata[trm_pkg::PATH_DST_LSB +: trm_pkg::SEL_W];
  assign w_hop = pwdata[trm_pkg::PATH_HOP_LSB +: trm_pkg::SEL_W];
  assign wr    = acc_stb && pwrite;
  assign rd    = acc_stb && !pwrite;

  trm_sel_check u_chk (
    .src (w_src),
    .dst (w_dst),
    .hop (w_hop),
    .ok  (path_ok)
  );

  // register file next state; refused writes touch only the sticky error flags
  always_comb begin
    open_d    = open_q;
    lvl_d     = lvl_q;
    src_d     = src_q;
    dst_d     = dst_q;
    hop_d     = hop_q;
    notopn_d  = notopn_q;
    badset_d  = badset_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (wr) begin
      unique case (paddr)
        trm_pkg::REG_CTRL: begin
          if (pwdata[trm_pkg::CTRL_OPEN_BIT]) begin
            open_d   = 1'b1;
            notopn_d = 1'b0;
          end else if (!open_q) begin
            notopn_d  = 1'b1;
            pslverr_d = 1'b1;
          end else begin
            if (pwdata[trm_pkg::CTRL_CLEAR_BIT] || pwdata[trm_pkg::CTRL_RELEASE_BIT]) begin
              src_d = trm_pkg::route_sel_nothing;
              dst_d = trm_pkg::route_sel_nothing;
              hop_d = trm_pkg::route_sel_nothing;
            end
            if (pwdata[trm_pkg::CTRL_RELEASE_BIT]) begin
              open_d = 1'b0;
            end
          end
        end
        trm_pkg::REG_SW_LVL: begin
          if (!open_q) begin
            notopn_d  = 1'b1;
            pslverr_d = 1'b1;
          end else begin
            lvl_d = pwdata[0];
          end
        end
        trm_pkg::REG_PATH: begin
          if (!open_q) begin
            notopn_d  = 1'b1;
            pslverr_d = 1'b1;
          end else if (!path_ok) begin
            badset_d  = 1'b1;
            pslverr_d = 1'b1;
          end else begin
            src_d    = w_src;
            dst_d    = w_dst;
            hop_d    = w_hop;
            badset_d = 1'b0;
          end
        end
        trm_pkg::REG_STATUS: begin
          // write one clears sticky error flags
          if (pwdata[trm_pkg::ST_NOTOPN_BIT]) notopn_d = 1'b0;
          if (pwdata[trm_pkg::ST_BADSET_BIT]) badset_d = 1'b0;
        end
        default: pslverr_d = 1'b1;
      endcase
    end else if (rd) begin
      unique case (paddr)
        trm_pkg::REG_CTRL:   prdata_d = 32'h0000_0000;
        trm_pkg::REG_SW_LVL: prdata_d = {31'h0000_0000, lvl_q};
        trm_pkg::REG_PATH:   prdata_d = {8'h00, hop_q, dst_q, src_q};
        trm_pkg::REG_STATUS: prdata_d = {29'h0000_0000, badset_q, notopn_q, open_q};
        default:             pslverr_d = 1'b1;
      endcase
    end
    // answer loads in the wait cycle; state moves only at the completing edge
    if (pready) begin
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
    end else begin
      open_d   = open_q;
      lvl_d    = lvl_q;
      src_d    = src_q;
      dst_d    = dst_q;
      hop_d    = hop_q;
      notopn_d = notopn_q;
      badset_d = badset_q;
    end
  end

  // prdata is registered, so read data appears with the registered answer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      open_q    <= 1'b0;
      lvl_q     <= trm_pkg::SW_LVL_RST;
      src_q     <= trm_pkg::SEL_RST;
      dst_q     <= trm_pkg::SEL_RST;
      hop_q     <= trm_pkg::SEL_RST;
      notopn_q  <= 1'b0;
      badset_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      open_q    <= open_d;
      lvl_q     <= lvl_d;
      src_q     <= src_d;
      dst_q     <= dst_d;
      hop_q     <= hop_d;
      notopn_q  <= notopn_d;
      badset_q  <= badset_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // routing mux: source level picked, destination and hop driven
  always_comb begin
    logic src_lvl;
    src_lvl    = 1'b0;
    coax_out_d = 1'b0;
    coax_oe_d  = 1'b0;
    line_out_d = 8'h00;
    line_oe_d  = 8'h00;
    if (src_q == trm_pkg::route_sel_faceplate_coax) src_lvl = coax_in;
    else if (src_q == trm_pkg::route_sel_sw_level)  src_lvl = lvl_q;
    for (int i = 0; i < trm_pkg::LINES; i++) begin
      if (src_q == trm_pkg::route_sel_bus_line_0 + 8'(i)) src_lvl = line_in[i];
    end
    // none selector leaves every pin undriven
    if (dst_q == trm_pkg::route_sel_faceplate_coax) begin
      coax_out_d = src_lvl;
      coax_oe_d  = 1'b1;
    end
    for (int i = 0; i < trm_pkg::LINES; i++) begin
      if ((dst_q == trm_pkg::route_sel_bus_line_0 + 8'(i)) || (hop_q == trm_pkg::route_sel_bus_line_0 + 8'(i))) begin
        line_out_d[i] = src_lvl;
        line_oe_d[i]  = 1'b1;
      end
    end
  end

  // one cycle of latency on pins keeps every output on a flip-flop
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      coax_out_q <= 1'b0;
      coax_oe_q  <= 1'b0;
      line_out_q <= 8'h00;
      line_oe_q  <= 8'h00;
    end else begin
      coax_out_q <= coax_out_d;
      coax_oe_q  <= coax_oe_d;
      line_out_q <= line_out_d;
      line_oe_q  <= line_oe_d;
    end
  end

  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign coax_out = coax_out_q;
  assign coax_oe  = coax_oe_q;
  assign line_out = line_out_q;
  assign line_oe  = line_oe_q;
endmodule

// *** src/trm_pkg.sv ***
// trigger route matrix package: register map, selector codes, field layout
// assumes a 32-bit apb slave with word-aligned registers
package trm_pkg;
  // register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_SW_LVL  = 12'h004;
  localparam logic [11:0] REG_PATH    = 12'h008;
  localparam logic [11:0] REG_STATUS  = 12'h00c;
  // ctrl bits (write one to act)
  localparam int CTRL_OPEN_BIT    = 0;
  localparam int CTRL_RELEASE_BIT = 1;
  localparam int CTRL_CLEAR_BIT   = 2;
  // path field positions
  localparam int PATH_SRC_LSB = 0;
  localparam int PATH_DST_LSB = 8;
  localparam int PATH_HOP_LSB = 16;
  localparam int SEL_W        = 8;
  localparam int LINES        = 8;
  // status bits
  localparam int ST_OPEN_BIT   = 0;
  localparam int ST_NOTOPN_BIT = 1;
  localparam int ST_BADSET_BIT = 2;
  // selector encoding
  localparam logic [7:0] route_sel_nothing        = 8'h00;
  localparam logic [7:0] route_sel_faceplate_coax = 8'h02;
  localparam logic [7:0] route_sel_sw_level       = 8'h03;
  localparam logic [7:0] route_sel_bus_line_0     = 8'h6f;
  localparam logic [7:0] route_sel_bus_line_7     = 8'h76;
  // reset values
  localparam logic       SW_LVL_RST = 1'b0;
  localparam logic [7:0] SEL_RST    = 8'h00;
endpackage

// *** src/trm_sel_check.sv ***
// selector validity check for one route path
// assumes selectors use the package encoding
`timescale 1ns/1ps
module trm_sel_check (
  input  wire logic [7:0] src,
  input  wire logic [7:0] dst,
  input  wire logic [7:0] hop,
  output logic            ok
);
  logic src_line, dst_line, hop_line;
  // line codes are a contiguous range
  assign src_line = (src >= trm_pkg::route_sel_bus_line_0) && (src <= trm_pkg::route_sel_bus_line_7);
  assign dst_line = (dst >= trm_pkg::route_sel_bus_line_0) && (dst <= trm_pkg::route_sel_bus_line_7);
  assign hop_line = (hop >= trm_pkg::route_sel_bus_line_0) && (hop <= trm_pkg::route_sel_bus_line_7);
  // source, destination and hop legality checked together
  always_comb begin
    logic s_ok, d_ok, h_ok;
    s_ok = src_line || (src == trm_pkg::route_sel_faceplate_coax) || (src == trm_pkg::route_sel_sw_level);
    d_ok = dst_line || (dst == trm_pkg::route_sel_faceplate_coax);
    // hop only for soft level to faceplate; required there
    if ((src == trm_pkg::route_sel_sw_level) && (dst == trm_pkg::route_sel_faceplate_coax)) begin
      h_ok = hop_line;
    end else begin
      h_ok = (hop == trm_pkg::route_sel_nothing);
    end
    ok = s_ok && d_ok && h_ok && (src != dst);
  end
endmodule

// *** src/trm_apb_slave.sv ***
// apb handshake front end: one wait state, then a registered ready pulse
// assumes apb3 master, 32-bit data
`timescale 1ns/1ps
module trm_apb_slave (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  output logic             pready,
  output logic             acc_stb
);
  logic pready_q, pready_d;

  // the wait state gives the registered read data time to stand before ready
  always_comb begin
    pready_d = psel && penable && !pready_q;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  assign pready  = pready_q;
  assign acc_stb = psel && penable;
endmodule

// *** test/trm_properties.sv ***
// checker on the route matrix ports: apb answer timing and pin update timing
// assumes it is bound into every trigger_route_matrix instance
`timescale 1ns/1ps
module trm_properties (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        coax_oe,
  input wire logic [7:0]  line_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // an access phase (wait or ready cycle), and a read of one offset
  wire acc = psel && penable;
  sequence s_rd(logic [11:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence s_bad;
    acc && !pready && paddr > 12'h00c;
  endsequence
  AST_READY: assert property (pready |-> $past(acc) && !$past(pready)) else $error("pready timing");
  AST_ERR_AFTER_ACC: assert property (pslverr |-> $past(acc)) else $error("stray pslverr");
  AST_RD_ONLY_AFTER_RD: assert property (prdata != 32'h0 |-> $past(acc) && !$past(pwrite))
    else $error("stray prdata");
  AST_SWLVL_ONE_BIT: assert property (s_rd(12'h004) |=> prdata[31:1] == 31'h0) else $error("level width");
  AST_PATH_FIELDS: assert property (s_rd(12'h008) |=> prdata[31:24] == 8'h00) else $error("path top");
  AST_CTRL_READS_ZERO: assert property (s_rd(12'h000) |=> prdata == 32'h0) else $error("ctrl read");
  AST_UNMAPPED: assert property (s_bad |=> pslverr && prdata == 32'h0) else $error("unmapped");
  // routes only move two edges after the access that changed them
  AST_PIN_TIMING: assert property ($changed({coax_oe, line_oe}) |-> $past(acc, 2))
    else $error("pins moved without access");
endmodule

bind trigger_route_matrix trm_properties u_props (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .coax_oe(coax_oe), .line_oe(line_oe));

// *** test/trm_far_side.sv ***
// far side: chassis trigger lines and faceplate coax, pulled up when idle
// assumes the bench changes ext_en and ext_val just after a rising edge
`timescale 1ns/1ps
module trm_far_side (
  input  wire logic       coax_oe,
  input  wire logic       coax_out,
  input  wire logic [7:0] line_oe,
  input  wire logic [7:0] line_out,
  input  wire logic [8:0] ext_en,
  input  wire logic [8:0] ext_val,
  output logic            coax_in,
  output logic [7:0]      line_in
);
  // wire level: device first, then far driver, else the pull-up
  always_comb begin
    coax_in = coax_oe ? coax_out : (ext_en[8] ? ext_val[8] : 1'b1);
    for (int i = 0; i < 8; i++) begin
      line_in[i] = line_oe[i] ? line_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

// *** test/trigger_route_matrix_tb.sv ***
// bench for the route matrix: apb calls with expected values
// assumes read data and error are taken at the edge where pready is high
`timescale 1ns/1ps
module trigger_route_matrix_tb;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic        coax_in, coax_out, coax_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  line_in, line_out, line_oe, b;
  logic [8:0]  ext_en, ext_val;
  int          failures, total_checks;
  trigger_route_matrix DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coax_in(coax_in), .coax_out(coax_out), .coax_oe(coax_oe),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
  trm_far_side u_far (.coax_oe(coax_oe), .coax_out(coax_out), .line_oe(line_oe),
    .line_out(line_out), .ext_en(ext_en), .ext_val(ext_val), .coax_in(coax_in), .line_in(line_in));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; answer taken at the ready edge, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 10);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // pins after the route settles; undriven out bits are masked off
  task automatic pins(input logic [17:0] exp);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({coax_oe, coax_oe & coax_out, line_oe, line_oe & line_out}, exp);
    @(posedge clock);
  endtask
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_en = 9'h100;
    ext_val = 9'h000;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, trm_pkg::REG_SW_LVL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, trm_pkg::REG_SW_LVL, 32'h1);
    chk(err, 32'h1);
    apb(1'b0, trm_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, trm_pkg::REG_STATUS, 32'h6);
    apb(1'b1, trm_pkg::REG_CTRL, 32'h1);
    apb(1'b0, trm_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1);
    // faceplate to each bus line, both levels
    for (int k = 0; k < 8; k++) begin
      b = 8'h01 << k;
      apb(1'b1, trm_pkg::REG_PATH, {16'h0, trm_pkg::route_sel_bus_line_0 + 8'(k), 8'h02});
      chk(err, 32'h0);
      apb(1'b0, trm_pkg::REG_PATH, 32'h0);
      chk(rd, {16'h0, 8'h6f + 8'(k), 8'h02});
      for (int v = 0; v < 2; v++) begin
        ext_val <= {v[0], 8'h00};
        pins({2'b00, b, v[0] ? b : 8'h00});
      end
    end
    // bus line 7 back to the faceplate
    ext_en <= 9'h080;
    ext_val <= 9'h080;
    apb(1'b1, trm_pkg::REG_PATH, 32'h0000_0276);
    pins({2'b11, 16'h0});
    ext_val <= 9'h000;
    pins({2'b10, 16'h0});
    // soft level to faceplate through hop line 3
    apb(1'b1, trm_pkg::REG_SW_LVL, 32'h1);
    apb(1'b0, trm_pkg::REG_SW_LVL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, trm_pkg::REG_PATH, 32'h0072_0203);
    pins({2'b11, 8'h08, 8'h08});
    apb(1'b1, trm_pkg::REG_SW_LVL, 32'h0);
    pins({2'b10, 8'h08, 8'h00});
    // illegal paths are refused and leave the route alone
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, trm_pkg::REG_PATH, i == 0 ? 32'h0302 : i == 1 ? 32'h0203 : i == 2 ? 32'h0070_6f02 : 32'h6f6f);
      chk(err, 32'h1);
      apb(1'b0, trm_pkg::REG_PATH, 32'h0);
      chk(rd, 32'h0072_0203);
    end
    apb(1'b0, trm_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, trm_pkg::REG_CTRL, 32'h4);
    apb(1'b0, trm_pkg::REG_PATH, 32'h0);
    chk(rd, 32'h0);
    pins(18'h0);
    apb(1'b1, trm_pkg::REG_CTRL, 32'h2);
    apb(1'b1, trm_pkg::REG_PATH, 32'h0000_6f02);
    chk(err, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0000_0000, err}, 32'h1);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule
